// File: rtl/chs_buf2.sv
// Two-entry valid/ready buffer for 16-bit words.
`timescale 1ns/1ps
`default_nettype none
`include "chs_defs.svh"
module chs_buf2 (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [`CHS_DATA_W-1:0] in_data,
  input  wire logic                   in_valid,
  output logic                        in_ready,
  output logic [`CHS_DATA_W-1:0]      out_data,
  output logic                        out_valid,
  input  wire logic                   out_ready
);
  logic [`CHS_DATA_W-1:0] mem_q [`CHS_BUF_DEPTH];
  logic                   wp_q;
  logic                   rp_q;
  logic [1:0]             cnt_q;
  wire                    push = in_valid && in_ready;
  wire                    pop  = out_valid && out_ready;
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= `CHS_RST_DATA;
      mem_q[1] <= `CHS_RST_DATA;
    end
    else
    begin
      if (push)
      begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

// File: rtl/chs_card_port.sv
// Card end: mode, selects, byte lanes, strobes and DMA handshake.
// Functional notes
// [R01] Host leaves input acknowledge open in memory mode.
// [R02] Input acknowledge only on selected I/O reads.
// [R03] Host may gate input buffers with acknowledge.
// [R04] Request raised when card ready to transfer.
// [R05] Read strobe reads, write strobe writes during DMA.
// [R06] Request held until grant, re-raised if more.
// [R07] Request undriven when card not selected.
// [R08] Read data driven while read strobe low.
// [R09] Card selects choose byte lanes with A0.
// [R10] Odd byte steered to low lanes for 8-bit.
// [R11] Task file and control block chip selects.
// [R12] No chip selects during grant; 16-bit words.
// [R13] Role select grounded master, open slave.
// [R14] Write data captured on write strobe rising edge.
// [R15] Output enable reads memory, info, config.
// [R16] In I/O mode output enable reads info/config.
// [R17] IDE mode only while mode select low.
// [R18] Attribute select high common, low attribute.
// [R19] Host asserts grant to start each transfer.
// [R20] Task file uses low byte; data 16 bits.
// [R21] Three low address lines pick task register.
// [R22] Strobes and selects synchronised, edges after.
// [R23] I/O strobes and role ignored in memory mode.
`timescale 1ns/1ps
`default_nettype none
`include "chs_defs.svh"
module chs_card_port (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  chs_link_if.card                       link,
  input  wire logic                      dev_selected,
  input  wire logic                      xfer_pending,
  output logic                           xfer_is_read,
  output logic [`CHS_DATA_W-1:0]         rd_word_in_data,
  input  wire logic [`CHS_DATA_W-1:0]    rd_data,
  input  wire logic                      rd_data_valid,
  output logic                           rd_data_ready,
  output logic [`CHS_DATA_W-1:0]         wr_data,
  output logic                           wr_valid,
  input  wire logic                      wr_ready,
  output logic [`CHS_ADDR_W-1:0]         wr_addr,
  output logic [1:0]                     wr_lanes,
  output logic                           wr_is_dma,
  output logic                           sel_taskfile,
  output logic                           sel_ctrl_block,
  output logic                           sel_attr,
  output logic                           sel_info_cfg,
  output logic                           is_master,
  output chs_pkg::chs_mode_t             mode
);
  localparam int NS = 9;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  wire  [NS-1:0] raw = {link.card_sel_low_n, link.card_sel_high_n, link.attr_sel_n,
                        link.output_enable_n, link.io_read_strobe_n,
                        link.io_write_strobe_n, link.ide_mode_select_n,
                        link.role_select_n, link.xfer_grant_n};
  // Two-stage synchroniser; the third stage only feeds edge detection.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
    end
    else
    begin
      s1_q <= raw;   // [R22]
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  wire ce1_n   = s2_q[8];
  wire ce2_n   = s2_q[7];
  wire reg_n   = s2_q[6];
  wire oe_n    = s2_q[5];
  wire io_read_strobe_n_n  = s2_q[4];
  wire io_write_strobe_n_n  = s2_q[3];
  wire ide_n   = s2_q[2];
  wire role_n  = s2_q[1];
  wire grant_n = s2_q[0];
  wire wr_rise = s2_q[3] && !s3_q[3];   // [R22]

  function automatic logic [1:0] lanes(input logic c1n, input logic c2n, input logic a0);
    lanes = !c2n ? {1'b1, !c1n && !a0} : (!c1n ? {a0, !a0} : 2'b00);
  endfunction

  wire is_ide = !ide_n;   // [R17]
  wire is_io  = !is_ide && !reg_n && (!io_read_strobe_n_n || !io_write_strobe_n_n);
  assign mode = is_ide ? chs_pkg::CHS_MODE_IDE :
                (is_io ? chs_pkg::CHS_MODE_IO : chs_pkg::CHS_MODE_MEM);
  wire io_en  = (mode != chs_pkg::CHS_MODE_MEM);   // [R23]
  wire grant  = is_ide && !grant_n;
  wire [1:0] pc_lanes = lanes(ce1_n, ce2_n, link.addr[0]);   // [R09]
  wire odd_only = !is_ide && ce2_n && !ce1_n && link.addr[0];   // [R10]
  wire pc_sel   = !is_ide && (pc_lanes != 2'b00);
  // In IDE mode the two card-select pins carry the task-file and control chip selects.
  assign sel_taskfile   = is_ide && !ce1_n && !grant;   // [R11] [R12]
  assign sel_ctrl_block = is_ide && !ce2_n && !grant;   // [R11]
  assign sel_attr       = !is_ide && !reg_n;   // [R18]
  assign sel_info_cfg   = pc_sel && !reg_n && !oe_n;   // [R15] [R16]
  wire tf_or_cb = sel_taskfile || sel_ctrl_block;
  wire io_rd    = io_en && !io_read_strobe_n_n && (pc_sel || tf_or_cb || grant);   // [R08] [R23]
  wire mem_rd   = pc_sel && !oe_n && ((mode == chs_pkg::CHS_MODE_MEM) || !reg_n);
  wire rd_act   = io_rd || mem_rd;
  wire [`CHS_ADDR_W-1:0] dec_addr =
    is_ide ? {{(`CHS_ADDR_W-`CHS_TF_ADDR_W){1'b0}}, link.addr[`CHS_TF_ADDR_W-1:0]}   // [R21]
           : link.addr;

  logic master_q;
  logic req_q;
  logic dma_rd_q;
  logic [`CHS_DATA_W-1:0] rdo_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      master_q <= 1'b0;
      req_q    <= 1'b0;
      dma_rd_q <= 1'b1;
      rdo_q    <= `CHS_RST_DATA;
    end
    else
    begin
      if (is_ide)
        master_q <= !role_n;   // [R13] [R23]
      if (grant)
        req_q <= 1'b0;   // [R06]
      else
        req_q <= is_ide && xfer_pending;   // [R04] [R06]
      if (grant && !io_read_strobe_n_n)
        dma_rd_q <= 1'b1;   // [R05]
      else if (grant && !io_write_strobe_n_n)
        dma_rd_q <= 1'b0;   // [R05]
      if (rd_act)
        rdo_q <= rd_data;
    end
  end
  assign is_master       = master_q;
  assign xfer_is_read    = dma_rd_q;
  assign rd_word_in_data = rdo_q;
  assign rd_data_ready   = rd_act;

  // Odd byte is moved to D7..D0 for byte hosts; task file uses the low byte only.
  wire [`CHS_DATA_W-1:0] swapped = {{`CHS_BYTE_W{1'b0}}, rdo_q[`CHS_DATA_W-1:`CHS_ODD_LO]};
  wire [`CHS_DATA_W-1:0] lowbyte = {{`CHS_BYTE_W{1'b0}}, rdo_q[`CHS_BYTE_W-1:0]};
  assign link.card_data = grant ? rdo_q :   // [R12] [R20]
                          (tf_or_cb ? lowbyte : (odd_only ? swapped : rdo_q));   // [R10] [R20]
  assign link.card_data_oe = rd_act && rd_data_valid;   // [R08] [R15]

  assign link.xfer_request    = req_q;
  assign link.xfer_request_oe = is_ide && dev_selected;   // [R07]
  // Acknowledge driven only in I/O mode, low while a selected I/O read is answered.
  assign link.input_ack_oe = (mode == chs_pkg::CHS_MODE_IO);   // [R02]
  assign link.input_ack_n  = !(io_rd && pc_sel);   // [R02]

  // The selects and the attribute select rise with the strobe, so a write is qualified
  // by what stood while the synchronised strobe was still low.
  logic                   wok_q;
  logic                   wgr_q;
  logic                   wodd_q;
  logic [1:0]             wln_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wok_q  <= 1'b0;
      wgr_q  <= 1'b0;
      wodd_q <= 1'b0;
      wln_q  <= 2'b00;
    end
    else if (!io_write_strobe_n_n)
    begin
      wok_q  <= io_en && (pc_sel || tf_or_cb || grant);   // [R14] [R23]
      wgr_q  <= grant;   // [R12]
      wodd_q <= odd_only;   // [R10]
      wln_q  <= is_ide ? (grant ? 2'b11 : 2'b01) : pc_lanes;   // [R20]
    end
  end
  wire wr_take = wr_rise && wok_q;   // [R14]

  wire [`CHS_DATA_W-1:0] wr_in = wodd_q ? {link.host_data[`CHS_BYTE_W-1:0],
                                             {`CHS_BYTE_W{1'b0}}} : link.host_data;
  chs_buf2 u_wbuf (
    .clk       (clk),
    .rstn      (rstn),
    .in_data   (wr_in),
    .in_valid  (wr_take),   // [R14]
    .in_ready  (),
    .out_data  (wr_data),
    .out_valid (wr_valid),
    .out_ready (wr_ready)
  );
  logic [`CHS_ADDR_W-1:0] wa_q;
  logic [1:0]             wl_q;
  logic                   wd_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wa_q <= `CHS_RST_ADDR;
      wl_q <= 2'b00;
      wd_q <= 1'b0;
    end
    else if (wr_take)
    begin
      wa_q <= dec_addr;
      wl_q <= wln_q;   // [R20]
      wd_q <= wgr_q;
    end
  end
  assign wr_addr   = wa_q;
  assign wr_lanes  = wl_q;
  assign wr_is_dma = wd_q;
endmodule
`default_nettype wire

// File: rtl/chs_defs.svh
// Constants shared by the card port and the host port.
`ifndef CHS_DEFS_SVH
`define CHS_DEFS_SVH
`define CHS_TF_ADDR_W    3
`define CHS_ADDR_W       11
`define CHS_DATA_W       16
`define CHS_BYTE_W       8
`define CHS_ODD_LO       8
`define CHS_SYNC_STAGES  2
`define CHS_BUF_DEPTH    2
`define CHS_RST_DATA     16'h0000
`define CHS_RST_ADDR     11'h000
`endif

// File: rtl/chs_host_port.sv
// Host end: drives one access or DMA word per command.
`timescale 1ns/1ps
`default_nettype none
`include "chs_defs.svh"
module chs_host_port (
  input  wire logic                   clk,
  input  wire logic                   rstn,
  chs_link_if.host                    link,
  input  wire logic                   ide_mode,
  input  wire logic                   master_strap,
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire logic                   cmd_write,
  input  wire logic                   cmd_io,
  input  wire logic                   cmd_attr,
  input  wire logic                   cmd_dma,
  input  wire logic [1:0]             cmd_sel_n,
  input  wire logic [`CHS_ADDR_W-1:0] cmd_addr,
  input  wire logic [`CHS_DATA_W-1:0] cmd_wdata,
  output logic [`CHS_DATA_W-1:0]      rsp_data,
  output logic                        rsp_valid,
  output logic                        rd_buf_en
);
  chs_pkg::chs_host_state_t st_q;
  logic                   wr_q;
  logic                   io_q;
  logic                   attr_q;
  logic                   dma_q;
  logic [1:0]             sel_q;
  logic [`CHS_ADDR_W-1:0] addr_q;
  logic [`CHS_DATA_W-1:0] wd_q;
  logic [`CHS_DATA_W-1:0] rd_q;
  logic                   rv_q;
  logic [2:0]             hold_q;
  wire dma_go = ide_mode && link.xfer_request_oe && link.xfer_request;
  wire take   = (st_q == chs_pkg::CHS_H_IDLE) && cmd_valid && (!cmd_dma || dma_go);
  assign cmd_ready = take;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q   <= chs_pkg::CHS_H_IDLE;
      wr_q   <= 1'b0;
      io_q   <= 1'b0;
      attr_q <= 1'b0;
      dma_q  <= 1'b0;
      sel_q  <= 2'b11;
      addr_q <= `CHS_RST_ADDR;
      wd_q   <= `CHS_RST_DATA;
      rd_q   <= `CHS_RST_DATA;
      rv_q   <= 1'b0;
      hold_q <= 3'h0;
    end
    else
    begin
      rv_q <= 1'b0;
      case (st_q)
        chs_pkg::CHS_H_IDLE:
          if (take)
          begin
            wr_q   <= cmd_write;
            io_q   <= cmd_io || ide_mode;
            attr_q <= cmd_attr;
            dma_q  <= cmd_dma;
            sel_q  <= cmd_dma ? 2'b11 : cmd_sel_n;
            addr_q <= cmd_addr;
            wd_q   <= cmd_wdata;
            st_q   <= chs_pkg::CHS_H_ASSERT;
          end
        chs_pkg::CHS_H_ASSERT:
        begin
          hold_q <= 3'h0;
          st_q   <= chs_pkg::CHS_H_HOLD;
        end
        chs_pkg::CHS_H_HOLD:
        begin
          hold_q <= hold_q + 3'h1;
          // Strobe held long enough for the card's synchroniser and data path.
          if (hold_q == 3'h5)
          begin
            rd_q <= link.card_data;
            rv_q <= !wr_q;
            st_q <= chs_pkg::CHS_H_DONE;
          end
        end
        chs_pkg::CHS_H_DONE:
        begin
          dma_q <= 1'b0;
          st_q  <= chs_pkg::CHS_H_IDLE;
        end
        default:
          st_q <= chs_pkg::CHS_H_IDLE;
      endcase
    end
  end
  wire strobe = (st_q == chs_pkg::CHS_H_HOLD);
  wire active = strobe || (st_q == chs_pkg::CHS_H_ASSERT);
  assign link.addr              = addr_q;
  assign link.host_data         = wd_q;
  assign link.host_data_oe      = active && wr_q;
  assign link.card_sel_low_n    = active ? sel_q[0] : 1'b1;   // [R12]
  assign link.card_sel_high_n   = active ? sel_q[1] : 1'b1;   // [R12]
  assign link.attr_sel_n        = !(active && (attr_q || io_q) && !ide_mode);   // [R18]
  assign link.output_enable_n   = !(strobe && !wr_q && !io_q);
  assign link.io_read_strobe_n  = !(strobe && !wr_q && io_q);   // [R05]
  assign link.io_write_strobe_n = !(strobe && wr_q && io_q);   // [R05]
  assign link.ide_mode_select_n = !ide_mode;   // [R17]
  assign link.role_select_n     = !master_strap;
  assign link.xfer_grant_n      = !(active && dma_q);   // [R19]
  assign rd_buf_en              = link.input_ack_oe && !link.input_ack_n;   // [R03]
  assign rsp_data               = rd_q;
  assign rsp_valid              = rv_q;
endmodule
`default_nettype wire

// File: rtl/chs_link_if.sv
// Card edge pins shared by the host end and the card end.
`timescale 1ns/1ps
`default_nettype none
`include "chs_defs.svh"
interface chs_link_if;
  logic [`CHS_ADDR_W-1:0] addr;
  logic [`CHS_DATA_W-1:0] host_data;
  logic                   host_data_oe;
  logic [`CHS_DATA_W-1:0] card_data;
  logic                   card_data_oe;
  logic                   card_sel_low_n;
  logic                   card_sel_high_n;
  logic                   attr_sel_n;
  logic                   output_enable_n;
  logic                   io_read_strobe_n;
  logic                   io_write_strobe_n;
  logic                   ide_mode_select_n;
  logic                   role_select_n;
  logic                   xfer_grant_n;
  logic                   xfer_request;
  logic                   xfer_request_oe;
  logic                   input_ack_n;
  logic                   input_ack_oe;
  modport host (output addr, host_data, host_data_oe, card_sel_low_n, card_sel_high_n,
                attr_sel_n, output_enable_n, io_read_strobe_n, io_write_strobe_n,
                ide_mode_select_n, role_select_n, xfer_grant_n,
                input card_data, card_data_oe, xfer_request, xfer_request_oe,
                input_ack_n, input_ack_oe);
  modport card (input addr, host_data, host_data_oe, card_sel_low_n, card_sel_high_n,
                attr_sel_n, output_enable_n, io_read_strobe_n, io_write_strobe_n,
                ide_mode_select_n, role_select_n, xfer_grant_n,
                output card_data, card_data_oe, xfer_request, xfer_request_oe,
                input_ack_n, input_ack_oe);
endinterface
`default_nettype wire

// File: rtl/chs_pkg.sv
// Types shared by the card port and the host port.
package chs_pkg;
  typedef enum logic [2:0] {
    CHS_MODE_MEM = 3'b001,
    CHS_MODE_IO  = 3'b010,
    CHS_MODE_IDE = 3'b100
  } chs_mode_t;
  typedef enum logic [3:0] {
    CHS_H_IDLE   = 4'b0001,
    CHS_H_ASSERT = 4'b0010,
    CHS_H_HOLD   = 4'b0100,
    CHS_H_DONE   = 4'b1000
  } chs_host_state_t;
endpackage

// File: verif/chs_link_assertions.sv
// Interface-level checks between the host end and the card end.
`timescale 1ns/1ps
`default_nettype none
module chs_link_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic card_sel_low_n,
  input wire logic card_sel_high_n,
  input wire logic attr_sel_n,
  input wire logic output_enable_n,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic ide_mode_select_n,
  input wire logic xfer_grant_n,
  input wire logic xfer_request,
  input wire logic xfer_request_oe,
  input wire logic card_data_oe,
  input wire logic input_ack_n,
  input wire logic input_ack_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire ack_on = input_ack_oe && !input_ack_n;
  wire sel_any = !(card_sel_low_n && card_sel_high_n);
  sequence grant_start;
    $fell(xfer_grant_n);
  endsequence
  sequence io_read_start;
    $fell(io_read_strobe_n) && ide_mode_select_n && !attr_sel_n && sel_any;
  endsequence
  ack_on_read_a: assert property (io_read_start |-> ##[1:4] ack_on)
    else $error("input acknowledge missing on I/O read");
  ack_idle_off_a: assert property (io_read_strobe_n [*4] |-> !ack_on)
    else $error("input acknowledge outside an I/O read");
  ack_mem_off_a: assert property (!output_enable_n |-> !ack_on)
    else $error("input acknowledge during output-enable read");
  read_drive_a: assert property ($fell(io_read_strobe_n) && (!ide_mode_select_n || !attr_sel_n)
    |-> ##[1:4] card_data_oe)
    else $error("card not driving data on read strobe");
  data_release_a: assert property ((io_read_strobe_n && output_enable_n) [*4] |-> !card_data_oe)
    else $error("card drives data without a read strobe");
  oe_read_a: assert property ($fell(output_enable_n) && ide_mode_select_n
    |-> ##[1:4] card_data_oe)
    else $error("card not driving data on output enable");
  req_drop_a: assert property (grant_start |-> ##[1:3] !xfer_request)
    else $error("request not dropped after grant");
  req_hold_a: assert property (xfer_request && xfer_request_oe && xfer_grant_n
    ##1 xfer_request_oe && xfer_grant_n |-> xfer_request)
    else $error("request dropped before grant");
  grant_cause_a: assert property (grant_start |-> $past(xfer_request && xfer_request_oe))
    else $error("grant without a driven request");
  grant_nosel_a: assert property (!xfer_grant_n |-> card_sel_low_n && card_sel_high_n)
    else $error("chip select active during grant");
  dma_dir_a: assert property (grant_start
    |-> ##[1:2] (io_read_strobe_n != io_write_strobe_n))
    else $error("DMA transfer without exactly one strobe");
  req_pc_off_a: assert property (ide_mode_select_n [*4] |-> !xfer_request_oe)
    else $error("request driven outside IDE mode");
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench joining the host end and the card end.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  integer      seed = 32'h47026CE2;
  integer      miscompares = 0;
  integer      tests_run = 0;
  logic        ide_mode = 1'b0;
  logic        master_strap = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic        cmd_io = 1'b0;
  logic        cmd_attr = 1'b0;
  logic        cmd_dma = 1'b0;
  logic [1:0]  cmd_sel_n = 2'b11;
  logic [10:0] cmd_addr = 11'h000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        dev_selected = 1'b0;
  logic        xfer_pending = 1'b1;
  logic [15:0] rd_data = 16'h0000;
  logic        wr_ready = 1'b1;
  logic        stall = 1'b0;
  integer      acks = 0;
  logic        cmd_ready, rsp_valid, wr_valid, wr_is_dma, is_master, xfer_is_read, rd_buf_en;
  logic [15:0] rsp_data, wr_data, d;
  logic [1:0]  wr_lanes;
  logic [10:0] a, wr_addr;
  logic [31:0] er;
  logic [18:0] ew;
  logic [31:0] rq[$];
  logic [18:0] wq[$];
  chs_link_if u_link ();
  chs_host_port u_chs_host_port (.clk(clk), .rstn(rstn), .link(u_link), .ide_mode(ide_mode),
    .master_strap(master_strap), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_io(cmd_io), .cmd_attr(cmd_attr), .cmd_dma(cmd_dma),
    .cmd_sel_n(cmd_sel_n), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_data(rsp_data),
    .rsp_valid(rsp_valid), .rd_buf_en(rd_buf_en));
  chs_card_port u_chs_card_port (.clk(clk), .rstn(rstn), .link(u_link),
    .dev_selected(dev_selected), .xfer_pending(xfer_pending), .xfer_is_read(xfer_is_read),
    .rd_word_in_data(), .rd_data(rd_data), .rd_data_valid(1'b1), .rd_data_ready(),
    .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_lanes(wr_lanes),
    .wr_is_dma(wr_is_dma), .sel_taskfile(), .sel_ctrl_block(), .sel_attr(), .sel_info_cfg(),
    .is_master(is_master), .mode());
  chs_link_assertions u_chs_link_assertions (.clk(clk), .rstn(rstn),
    .card_sel_low_n(u_link.card_sel_low_n), .card_sel_high_n(u_link.card_sel_high_n),
    .attr_sel_n(u_link.attr_sel_n), .output_enable_n(u_link.output_enable_n),
    .io_read_strobe_n(u_link.io_read_strobe_n), .io_write_strobe_n(u_link.io_write_strobe_n),
    .ide_mode_select_n(u_link.ide_mode_select_n), .xfer_grant_n(u_link.xfer_grant_n),
    .xfer_request(u_link.xfer_request), .xfer_request_oe(u_link.xfer_request_oe),
    .card_data_oe(u_link.card_data_oe), .input_ack_n(u_link.input_ack_n),
    .input_ack_oe(u_link.input_ack_oe));
  always #10 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic issue(input logic io, input logic wr, input logic dma, input logic at,
                       input logic [1:0] sel, input logic [10:0] ad, input logic [15:0] wd);
    integer n;
    {cmd_io, cmd_write, cmd_dma, cmd_attr, cmd_sel_n} <= {io, wr, dma, at, sel};
    cmd_addr <= ad;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (cmd_ready !== 1'b1 && n < 60);
    cmd_valid <= 1'b0;
    chk("cmd_ready", 32'h1, {31'h0, cmd_ready});
    repeat (10) @(posedge clk);
  endtask
  // The back end stalls writes now and then; two buffer entries absorb it.
  always @(posedge clk)
    if (rstn) wr_ready <= !stall && (($random(seed) & 3) != 0);
  // Counts the cycles in which the host's input buffers are enabled by the acknowledge.
  always @(posedge clk)
    if (rd_buf_en === 1'b1) acks++;
  always @(posedge clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      er = (rq.size() > 0) ? rq.pop_front() : 32'h0000_0001;
      chk("rsp_data", {16'h0, er[15:0]}, {16'h0, rsp_data & er[31:16]});
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
    begin
      ew = (wq.size() > 0) ? wq.pop_front() : 19'h7FFFF;
      chk("wr_word", {13'h0, ew}, {13'h0, wr_is_dma, wr_lanes, wr_data});
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      a = 11'($random(seed));
      d = 16'($random(seed));
      wq.push_back({3'b011, d});
      issue(1'b1, 1'b1, 1'b0, 1'b0, 2'b00, {a[10:1], 1'b0}, d);
      d = 16'($random(seed));
      rd_data <= d;
      rq.push_back({16'hFFFF, d});
      issue(1'b1, 1'b0, 1'b0, 1'b0, 2'b00, {a[10:1], 1'b0}, 16'h0000);
      chk("wr_addr", {21'h0, a[10:1], 1'b0}, {21'h0, wr_addr});
      rq.push_back({16'h00FF, 8'h00, d[15:8]});
      issue(1'b1, 1'b0, 1'b0, 1'b0, 2'b10, {a[10:1], 1'b1}, 16'h0000);
      rq.push_back({16'hFFFF, d});
      issue(1'b0, 1'b0, 1'b0, i[0], 2'b00, {a[10:1], 1'b0}, 16'h0000);
    end
    // Eight I/O reads, each answered for six synchronised strobe-low cycles.
    chk("input_ack_cycles", 32'h30, 32'(acks));
    // A stalled back end: both buffer entries must keep their words in order.
    stall <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      d = 16'($random(seed));
      wq.push_back({3'b011, d});
      issue(1'b1, 1'b1, 1'b0, 1'b0, 2'b00, 11'h010, d);
    end
    repeat (2) @(posedge clk);
    chk("buf_head", {15'h0, 1'b1, wq[0][15:0]}, {15'h0, wr_valid, wr_data});
    chk("buf_kept", 32'h2, 32'(wq.size()));
    stall <= 1'b0;
    repeat (20) @(posedge clk);
    chk("buf_empty", 32'h0, {31'h0, wr_valid});
    ide_mode <= 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      master_strap <= m[0];
      repeat (8) @(posedge clk);
      chk("is_master", {31'h0, m[0]}, {31'h0, is_master});
    end
    chk("xfer_request_oe", 32'h0, {31'h0, u_link.xfer_request_oe});
    dev_selected <= 1'b1;
    repeat (8) @(posedge clk);
    chk("xfer_request", 32'h1, {31'h0, u_link.xfer_request & u_link.xfer_request_oe});
    for (int i = 0; i < 4; i++)
    begin
      d = 16'($random(seed));
      rd_data <= d;
      if (i[0]) wq.push_back({3'b111, d});
      else rq.push_back({16'hFFFF, d});
      issue(1'b0, i[0], 1'b1, 1'b0, 2'b11, 11'h000, d);
      chk("xfer_is_read", {31'h0, ~i[0]}, {31'h0, xfer_is_read});
    end
    repeat (20) @(posedge clk);
    chk("pending", 32'h0, 32'(rq.size() + wq.size()));
    test_done();
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
